/* src/ismc_seq.sv */
// Operation
// - memory command holds address ten periods
// - system-memory command holds address ten periods
// - i/o command holds address nineteen periods
// - next latch enable ten periods after command
// - same-type commands twelve periods apart
// - three periods from negation to command
// - command negated before next latch enable
`timescale 1ns/10ps
`include "ismc_defines.svh"

module ismc_seq #(
   parameter int BCLK_DIV = `ISMC_BCLK_DIV
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   output logic req_ready,
   input wire ismc_pkg::ismc_kind_t req_kind,
   input wire logic req_write,
   input wire logic req_wide,
   input wire logic req_short,
   input wire logic req_hi_byte,
   input wire logic [23:0] req_addr,
   input wire logic [15:0] req_wdata,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   output logic [6:0] la_out,
   output logic [19:0] sa_out,
   output logic sbhe_n,
   output logic addr_latch_n,
   output logic mem_rd_n,
   output logic mem_wr_n,
   output logic smem_rd_n,
   output logic smem_wr_n,
   output logic io_rd_n,
   output logic io_wr_n,
   input wire logic [15:0] sd_in,
   output logic [15:0] sd_out,
   output logic sd_oe,
   input wire logic chan_rdy
);
   import ismc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [7:0] div_r;                 // core clocks within one period
   logic tick;                        // one-cycle pulse per period
   ismc_state_t st_r;                 // sequencer state
   ismc_state_t st_nxt;
   logic [`ISMC_TCNT_W-1:0] ph_r;     // periods since latch enable / command
   ismc_kind_t kind_r;                // kind of access in flight
   ismc_kind_t last_kind_r;           // kind of the last command issued
   logic wr_r;                        // access in flight is a write
   logic [`ISMC_TELAP_W-1:0] len_r;   // command length for this access
   logic [23:0] addr_r;               // latched address
   logic bhe_r;                       // high byte enabled
   logic [15:0] wdata_r;              // write data
   logic ale_r;                       // latch enable active
   logic cmd_act_r;                   // command strobe active
   logic oe_r;                        // data bus driven
   logic rsp_valid_r;                 // answer pulse
   logic [15:0] rdata_r;              // captured read data
   logic [`ISMC_TCNT_W-1:0] on_cnt;   // periods since command asserted
   logic [`ISMC_TCNT_W-1:0] off_cnt;  // periods since command negated
   logic [`ISMC_TELAP_W-1:0] on_elap; // periods elapsed at this tick
   logic [`ISMC_TELAP_W-1:0] off_elap;
   logic [`ISMC_TELAP_W-1:0] ph_elap;
   logic [`ISMC_TELAP_W-1:0] hold_need; // address hold after last command
   logic [`ISMC_TELAP_W-1:0] len_sel;   // length chosen for a new request
   logic ale_ok;                      // a new latch enable is legal
   logic cmd_ok;                      // the command may be asserted
   logic ale_start;
   logic ale_end;
   logic cmd_start;
   logic cmd_done;

   ////////////////////////////////////////////////////////////////////////////
   // period divider: every interval below counts these ticks
   assign tick = (div_r == 8'(BCLK_DIV - 1));

   always_ff @(posedge clk)
   begin
      if (rst || tick)
         div_r <= 8'h00;
      else
         div_r <= div_r + 8'h01;
   end

   // periods since the last command edges
   ismc_tick_ctr #(.W(`ISMC_TCNT_W)) u_on_ctr (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .clear(cmd_start),
      .count(on_cnt)
   );

   ismc_tick_ctr #(.W(`ISMC_TCNT_W)) u_off_ctr (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .clear(cmd_done),
      .count(off_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // spacing decode; elapsed counts include the current tick
   assign on_elap = {1'b0, on_cnt} + 7'h01;
   assign off_elap = {1'b0, off_cnt} + 7'h01;
   assign ph_elap = {1'b0, ph_r} + 7'h01;

   // address may only move once the last command's hold has run out
   assign hold_need = (last_kind_r == ISMC_KIND_IO) ? `ISMC_HOLD_IO_T :
                      (last_kind_r == ISMC_KIND_SMEM) ? `ISMC_HOLD_SMEM_T :
                      `ISMC_HOLD_MEM_T;

   assign ale_ok = (on_elap >= hold_need) &&
                   (on_elap >= `ISMC_CMD_TO_ALE_T) &&
                   (off_elap >= `ISMC_NEG_TO_ALE_T) &&
                   !cmd_act_r;

   assign cmd_ok = (ph_elap >= `ISMC_ALE_TO_CMD_T) &&
                   (off_elap >= `ISMC_RECOVERY_T) &&
                   ((kind_r != last_kind_r) || (on_elap >= `ISMC_CMD_TO_CMD_T));

   // command length by access kind, slave width and shortening
   assign len_sel = (!req_short || req_kind == ISMC_KIND_IO) ? `ISMC_CMD_STD_T :
                    req_wide ? `ISMC_CMD_SHORT16_T : `ISMC_CMD_SHORT8_T;

   assign req_ready = (st_r == ISMC_ST_IDLE) && tick && ale_ok;
   assign ale_start = req_ready && req_valid;
   assign ale_end = (st_r == ISMC_ST_ALE) && tick && (ph_elap >= `ISMC_ALE_W_T);
   assign cmd_start = (st_r == ISMC_ST_SETUP) && tick && cmd_ok;
   // slave extends by holding ready low; sampled only once length is met
   assign cmd_done = (st_r == ISMC_ST_CMD) && tick && (ph_elap >= len_r) && chan_rdy;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r)
         ISMC_ST_IDLE:
            if (ale_start)
               st_nxt = ISMC_ST_ALE;
         ISMC_ST_ALE:
            if (ale_end)
               st_nxt = ISMC_ST_SETUP;
         ISMC_ST_SETUP:
            if (cmd_start)
               st_nxt = ISMC_ST_CMD;
         ISMC_ST_CMD:
            if (cmd_done)
               st_nxt = ISMC_ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state and phase counter
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r <= ISMC_ST_IDLE;
         ph_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         if (ale_start || cmd_start)
            ph_r <= '0;
         else if (tick && !(&ph_r))
            ph_r <= ph_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request capture at latch enable; address stays until the next one
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         kind_r <= ISMC_KIND_MEM;
         wr_r <= 1'b0;
         len_r <= `ISMC_CMD_STD_T;
         addr_r <= 24'h00_0000;
         bhe_r <= 1'b0;
         wdata_r <= 16'h0000;
      end
      else if (ale_start)
      begin
         kind_r <= req_kind;
         wr_r <= req_write;
         len_r <= len_sel;
         addr_r <= req_addr;
         bhe_r <= req_hi_byte;
         wdata_r <= req_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // strobes, data drive and the answer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ale_r <= 1'b0;
         cmd_act_r <= 1'b0;
         oe_r <= 1'b0;
         last_kind_r <= ISMC_KIND_MEM;
         rsp_valid_r <= 1'b0;
         rdata_r <= 16'h0000;
      end
      else
      begin
         rsp_valid_r <= cmd_done;
         if (ale_start)
            ale_r <= 1'b1;
         else if (ale_end)
            ale_r <= 1'b0;
         if (cmd_start)
         begin
            cmd_act_r <= 1'b1;
            last_kind_r <= kind_r;
         end
         else if (cmd_done)
         begin
            cmd_act_r <= 1'b0;
            // read data taken as the command ends
            rdata_r <= wr_r ? rdata_r : sd_in;
         end
         // write data driven from latch enable until the command ends
         if (ale_start)
            oe_r <= req_write;
         else if (cmd_done)
            oe_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin decode
   assign addr_latch_n = !ale_r;
   assign la_out = addr_r[23:17];
   assign sa_out = addr_r[19:0];
   assign sbhe_n = !bhe_r;
   assign mem_rd_n = !(cmd_act_r && kind_r == ISMC_KIND_MEM && !wr_r);
   assign mem_wr_n = !(cmd_act_r && kind_r == ISMC_KIND_MEM && wr_r);
   assign smem_rd_n = !(cmd_act_r && kind_r == ISMC_KIND_SMEM && !wr_r);
   assign smem_wr_n = !(cmd_act_r && kind_r == ISMC_KIND_SMEM && wr_r);
   assign io_rd_n = !(cmd_act_r && kind_r == ISMC_KIND_IO && !wr_r);
   assign io_wr_n = !(cmd_act_r && kind_r == ISMC_KIND_IO && wr_r);
   assign sd_out = wdata_r;
   assign sd_oe = oe_r;
   assign rsp_valid = rsp_valid_r;
   assign rsp_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // checking: core-clock counts since the command edges
   localparam int HOLD_MEM_CYC = int'(`ISMC_HOLD_MEM_T) * BCLK_DIV;
   localparam int HOLD_SMEM_CYC = int'(`ISMC_HOLD_SMEM_T) * BCLK_DIV;
   localparam int HOLD_IO_CYC = int'(`ISMC_HOLD_IO_T) * BCLK_DIV;
   localparam int CMD_ALE_CYC = int'(`ISMC_CMD_TO_ALE_T) * BCLK_DIV;
   localparam int CMD_CMD_CYC = int'(`ISMC_CMD_TO_CMD_T) * BCLK_DIV;
   localparam int RECOV_CYC = int'(`ISMC_RECOVERY_T) * BCLK_DIV;
   localparam int NEG_ALE_CYC = int'(`ISMC_NEG_TO_ALE_T) * BCLK_DIV;

   logic [15:0] cyc_on_r;  // core clocks since command asserted
   logic [15:0] cyc_off_r; // core clocks since command negated
   logic seen_on_r;        // a command has been asserted
   logic seen_off_r;       // a command has been negated

   // free-running measure, independent of the period counters
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cyc_on_r <= 16'h0000;
         cyc_off_r <= 16'h0000;
         seen_on_r <= 1'b0;
         seen_off_r <= 1'b0;
      end
      else
      begin
         cyc_on_r <= cmd_start ? 16'h0000 : cyc_on_r + {15'h0000, !(&cyc_on_r)};
         cyc_off_r <= cmd_done ? 16'h0000 : cyc_off_r + {15'h0000, !(&cyc_off_r)};
         seen_on_r <= seen_on_r || cmd_start;
         seen_off_r <= seen_off_r || cmd_done;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   chk_mem_addr_hold: assert property (
      ($changed(addr_r) && seen_on_r && last_kind_r == ISMC_KIND_MEM)
      |-> (int'(cyc_on_r) >= HOLD_MEM_CYC))
      else $error("address moved too soon after memory command");

   chk_smem_addr_hold: assert property (
      ($changed(addr_r) && seen_on_r && last_kind_r == ISMC_KIND_SMEM)
      |-> (int'(cyc_on_r) >= HOLD_SMEM_CYC))
      else $error("address moved too soon after system-memory command");

   chk_io_addr_hold: assert property (
      ($changed(addr_r) && seen_on_r && last_kind_r == ISMC_KIND_IO)
      |-> (int'(cyc_on_r) >= HOLD_IO_CYC))
      else $error("address moved too soon after i/o command");

   chk_cmd_to_ale: assert property (
      ($rose(ale_r) && seen_on_r) |-> (int'(cyc_on_r) >= CMD_ALE_CYC))
      else $error("latch enable too soon after command");

   chk_same_cmd_space: assert property (
      ($rose(cmd_act_r) && $past(seen_on_r) && kind_r == $past(last_kind_r))
      |-> (int'($past(cyc_on_r)) >= CMD_CMD_CYC - 1))
      else $error("same-type commands too close");

   chk_cmd_recovery: assert property (
      ($rose(cmd_act_r) && $past(seen_off_r))
      |-> (int'($past(cyc_off_r)) >= RECOV_CYC - 1))
      else $error("command recovery too short");

   chk_neg_before_ale: assert property (
      ($rose(ale_r) && seen_off_r)
      |-> (!cmd_act_r && int'(cyc_off_r) >= NEG_ALE_CYC))
      else $error("command still active at latch enable");

   chk_cmd_min_len: assert property (
      $fell(cmd_act_r) |-> (int'($past(cyc_on_r)) >= int'(len_r) * BCLK_DIV - 1))
      else $error("command shorter than its length");

   chk_ready_end: assert property (
      $fell(cmd_act_r) |-> ($past(chan_rdy) && $past(tick)))
      else $error("command ended while slave not ready");

   chk_read_capture: assert property (
      ($fell(cmd_act_r) && !wr_r) |-> (rsp_valid && rsp_rdata == $past(sd_in)))
      else $error("read data not captured at command end");

endmodule

/* src/ismc_defines.svh */
`ifndef ISMC_DEFINES_SVH
`define ISMC_DEFINES_SVH

// width of the interval counters that count bus-clock periods (T)
`define ISMC_TCNT_W 6
// width of an elapsed-interval value, one bit above the counter
`define ISMC_TELAP_W 7
// default divider from the 125 MHz core clock to one T period
`define ISMC_BCLK_DIV 16

// intervals, in T periods (decimal figure beside each)
`define ISMC_ALE_W_T 7'h01        // 1 T, latch enable width
`define ISMC_ALE_TO_CMD_T 7'h02   // 2 T, latch enable asserted to command
`define ISMC_CMD_STD_T 7'h09      // 9 T, standard command width
`define ISMC_CMD_SHORT16_T 7'h03  // 3 T, shortened command, 16-bit slave
`define ISMC_CMD_SHORT8_T 7'h06   // 6 T, shortened command, 8-bit slave
`define ISMC_HOLD_MEM_T 7'h0A     // 10 T, address hold after memory command
`define ISMC_HOLD_SMEM_T 7'h0A    // 10 T, address hold after system-memory command
`define ISMC_HOLD_IO_T 7'h13      // 19 T, address hold after i/o command
`define ISMC_CMD_TO_ALE_T 7'h0A   // 10 T, command asserted to next latch enable
`define ISMC_CMD_TO_CMD_T 7'h0C   // 12 T, same-type command spacing
`define ISMC_RECOVERY_T 7'h03     // 3 T, command negated to next command
`define ISMC_NEG_TO_ALE_T 7'h01   // 1 T, command negated to next latch enable

`endif

/* src/ismc_pkg.sv */
package ismc_pkg;

   // kind of bus access
   typedef enum logic [1:0] {
      ISMC_KIND_MEM,
      ISMC_KIND_SMEM,
      ISMC_KIND_IO
   } ismc_kind_t;

   // sequencer states
   typedef enum logic [1:0] {
      ISMC_ST_IDLE,
      ISMC_ST_ALE,
      ISMC_ST_SETUP,
      ISMC_ST_CMD
   } ismc_state_t;

endpackage

/* src/ismc_tick_ctr.sv */
`timescale 1ns/10ps
`include "ismc_defines.svh"

// saturating counter of bus-clock periods since the last clear
module ismc_tick_ctr #(
   parameter int W = `ISMC_TCNT_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic clear,
   output logic [W-1:0] count
);

   logic [W-1:0] count_r; // periods elapsed, saturates at all ones

   ////////////////////////////////////////////////////////////////////////////
   // count; reset starts saturated so the first access is never held off
   always_ff @(posedge clk)
   begin
      if (rst)
         count_r <= '1;
      else if (clear)
         count_r <= '0;
      else if (tick && !(&count_r))
         count_r <= count_r + 1'b1;
   end

   assign count = count_r;

endmodule

/* dv/ismc_slave_model.sv */
`timescale 1ns/10ps

// isa slave: stretches commands by holding ready low, answers reads
module ismc_slave_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic mem_rd_n,
   input wire logic mem_wr_n,
   input wire logic smem_rd_n,
   input wire logic smem_wr_n,
   input wire logic io_rd_n,
   input wire logic io_wr_n,
   input wire logic [19:0] sa_out,
   input wire logic [15:0] wait_clk,
   output logic [15:0] sd_in,
   output logic chan_rdy
);
   logic cmd; // some command strobe low
   logic rd; // some read strobe low
   logic [15:0] cnt_r; // clk cycles since command start
   logic [15:0] sd_r; // last value, inverted while released
   logic [15:0] rdata; // answer word from the address

   //////////////////////////////////////////////////////////////////
   assign cmd = ~(mem_rd_n & mem_wr_n & smem_rd_n & smem_wr_n & io_rd_n & io_wr_n);
   assign rd = ~(mem_rd_n & smem_rd_n & io_rd_n);
   assign rdata = {sa_out[7:0], ~sa_out[7:0]};

   // count command length
   always_ff @(posedge clk)
   begin
      if (rst || !cmd)
         cnt_r <= 16'h0000;
      else
         cnt_r <= cnt_r + 16'h0001;
   end

   // ready dropped at command start, released after wait_clk
   assign chan_rdy = !(cmd && (cnt_r < wait_clk));

   // released bus toggles so stale data cannot pass
   always_ff @(posedge clk)
   begin
      if (rst)
         sd_r <= 16'hA5A5;
      else
         sd_r <= rd ? rdata : ~sd_r;
   end

   // data valid from command start, ahead of every deadline
   assign sd_in = rd ? rdata : sd_r;
endmodule

/* dv/tb.sv */
`timescale 1ns/10ps

module tb;
   import ismc_pkg::*;
   localparam int D = 2; // clk cycles per bus period

   typedef struct {
      ismc_kind_t kind;
      logic wr;
      logic wide;
      logic shrt;
      logic hi;
      logic [23:0] addr;
      logic [15:0] wdata;
      int len;
      int w;
   } ismc_row_t;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0, req_write = 1'b0, req_wide = 1'b0, req_short = 1'b0;
   logic req_hi_byte = 1'b0;
   ismc_kind_t req_kind = ISMC_KIND_MEM;
   logic [23:0] req_addr = 24'h00_0000;
   logic [15:0] req_wdata = 16'h0000, wait_clk = 16'h0000;
   logic req_ready, rsp_valid, sbhe_n, addr_latch_n, sd_oe, chan_rdy;
   logic mem_rd_n, mem_wr_n, smem_rd_n, smem_wr_n, io_rd_n, io_wr_n;
   logic [15:0] rsp_rdata, sd_in, sd_out, wdata_seen;
   logic [6:0] la_out;
   logic [19:0] sa_out;
   logic [5:0] sb, strobe_seen;
   logic cmd_p = 1'b0, ale_p = 1'b1, oe_seen, last_io;
   int n_mismatch = 0, comparisons = 0, cyc = 0;
   int t_as, t_neg, cmd_len, k;
   int t_kind [3];
   ismc_row_t rows [8];
   ismc_row_t cur;

   //////////////////////////////////////////////////////////////////
   ismc_seq #(.BCLK_DIV(D)) dut_u (.clk(clk), .rst(rst), .req_valid(req_valid),
      .req_ready(req_ready), .req_kind(req_kind), .req_write(req_write),
      .req_wide(req_wide), .req_short(req_short), .req_hi_byte(req_hi_byte),
      .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .la_out(la_out), .sa_out(sa_out), .sbhe_n(sbhe_n),
      .addr_latch_n(addr_latch_n), .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n),
      .smem_rd_n(smem_rd_n), .smem_wr_n(smem_wr_n), .io_rd_n(io_rd_n),
      .io_wr_n(io_wr_n), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe),
      .chan_rdy(chan_rdy));

   ismc_slave_model slave_u (.clk(clk), .rst(rst), .mem_rd_n(mem_rd_n),
      .mem_wr_n(mem_wr_n), .smem_rd_n(smem_rd_n), .smem_wr_n(smem_wr_n),
      .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .sa_out(sa_out), .wait_clk(wait_clk),
      .sd_in(sd_in), .chan_rdy(chan_rdy));

   //////////////////////////////////////////////////////////////////
   // compare tasks and closing
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_ge(input int got, input int lim);
      comparisons++;
      if (got < lim)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h below %h", $time, got, lim);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial
   begin
      forever #4 clk = ~clk;
   end

   initial
   begin
      #(20000 * 8);
      n_mismatch++;
      wrap_up();
   end

   //////////////////////////////////////////////////////////////////
   // bus monitor: spacing, command length, latched address
   assign sb = {mem_rd_n, mem_wr_n, smem_rd_n, smem_wr_n, io_rd_n, io_wr_n};
   always @(negedge clk)
   begin
      cyc++;
      if (rst)
      begin
         t_as = -1000;
         t_neg = -1000;
         t_kind = '{-1000, -1000, -1000};
         last_io = 1'b0;
      end
      else
      begin
         k = (&sb[5:4]) ? ((&sb[3:2]) ? 2 : 1) : 0;
         if (sb != 6'h3F && !cmd_p)
         begin
            check_ge(cyc - t_neg, 3 * D);
            check_ge(cyc - t_kind[k], 12 * D);
            t_as = cyc;
            t_kind[k] = cyc;
            strobe_seen = sb;
            last_io = (k == 2);
            // data drive seen while the command stands
            wdata_seen = sd_out;
            oe_seen = sd_oe;
         end
         if (sb == 6'h3F && cmd_p)
         begin
            t_neg = cyc;
            cmd_len = cyc - t_as;
         end
         if (!addr_latch_n && ale_p)
         begin
            check_ge(cyc - t_as, (last_io ? 19 : 10) * D);
            check_ge(cyc - t_neg, D);
            check_val({4'h0, la_out, sa_out, sbhe_n},
               {4'h0, cur.addr[23:17], cur.addr[19:0], ~cur.hi});
         end
      end
      cmd_p = (sb != 6'h3F) && !rst;
      ale_p = addr_latch_n;
   end

   //////////////////////////////////////////////////////////////////
   // request driver, inputs change off the rising edge
   task automatic launch(input ismc_row_t r);
      int n;
      // realign to a falling edge before driving
      @(negedge clk);
      cur = r;
      req_kind = r.kind;
      req_write = r.wr;
      req_wide = r.wide;
      req_short = r.shrt;
      req_hi_byte = r.hi;
      req_addr = r.addr;
      req_wdata = r.wdata;
      wait_clk = (r.w > 0) ? 16'((r.len + r.w) * D - 1) : 16'h0000;
      req_valid = 1'b1;
      n = 0;
      #1;
      while (req_ready !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         #1;
         n++;
      end
      if (n >= 400)
         n_mismatch++;
      @(negedge clk);
      req_valid = 1'b0;
   endtask

   task automatic finish(input ismc_row_t r);
      int n;
      logic [5:0] strobe_exp;
      logic [15:0] rd_exp;
      n = 0;
      strobe_exp = ~(6'h20 >> (2 * int'(r.kind) + int'(r.wr)));
      rd_exp = {r.addr[7:0], ~r.addr[7:0]};
      while (rsp_valid !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 400)
         n_mismatch++;
      // let the bus monitor record this falling edge first
      #1;
      check_val(32'(cmd_len), 32'((r.len + r.w) * D));
      check_val({26'h000_0000, strobe_seen}, {26'h000_0000, strobe_exp});
      if (r.wr)
         check_val({14'h0000, sd_oe, oe_seen, wdata_seen}, {14'h0000, 2'b01, r.wdata});
      else
         check_val({14'h0000, sd_oe, oe_seen, rsp_rdata}, {16'h0000, rd_exp});
   endtask

   //////////////////////////////////////////////////////////////////
   // main sequence: table of accesses, then a reset in the middle of a command
   initial
   begin
      rows[0] = '{ISMC_KIND_MEM, 1'b0, 1'b1, 1'b0, 1'b1, 24'h12_3456, 16'h0000, 9, 0};
      rows[1] = '{ISMC_KIND_MEM, 1'b1, 1'b1, 1'b1, 1'b0, 24'hFE_0011, 16'hBEEF, 3, 0};
      rows[2] = '{ISMC_KIND_MEM, 1'b0, 1'b0, 1'b1, 1'b0, 24'h00_4A5C, 16'h0000, 6, 2};
      rows[3] = '{ISMC_KIND_SMEM, 1'b1, 1'b0, 1'b0, 1'b1, 24'h0C_8001, 16'h1234, 9, 0};
      rows[4] = '{ISMC_KIND_SMEM, 1'b0, 1'b1, 1'b1, 1'b1, 24'h0D_00F3, 16'h0000, 3, 1};
      rows[5] = '{ISMC_KIND_IO, 1'b0, 1'b1, 1'b0, 1'b0, 24'h00_03F8, 16'h0000, 9, 0};
      rows[6] = '{ISMC_KIND_IO, 1'b1, 1'b0, 1'b1, 1'b0, 24'h00_0278, 16'h5AC3, 9, 3};
      rows[7] = '{ISMC_KIND_MEM, 1'b0, 1'b0, 1'b0, 1'b1, 24'hA5_5A66, 16'h0000, 9, 0};
      repeat (16) @(negedge clk);
      rst = 1'b0;
      foreach (rows[i])
      begin
         launch(rows[i]);
         finish(rows[i]);
      end
      // reset in the middle of a command
      launch(rows[3]);
      repeat (6) @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      check_val({23'h00_0000, sb, addr_latch_n, sd_oe, rsp_valid},
         {23'h00_0000, 6'h3F, 1'b1, 1'b0, 1'b0});
      check_val({5'h00, la_out, sa_out}, 32'h0000_0000);
      rst = 1'b0;
      launch(rows[0]);
      finish(rows[0]);
      wrap_up();
   end
endmodule
